// file: hdl/zdfs_flag_if.sv
`timescale 1ns/100ps
interface zdfs_flag_if;
	logic hitless_req;
	logic clr_entry;
	logic clr_exit;
	logic entry_flag;
	logic exit_flag;
	logic hitless_on;
	modport flag_side (
		input  hitless_req,
		input  clr_entry,
		input  clr_exit,
		output entry_flag,
		output exit_flag,
		output hitless_on
	);
	modport ctrl_side (
		output hitless_req,
		output clr_entry,
		output clr_exit,
		input  entry_flag,
		input  exit_flag,
		input  hitless_on
	);
endinterface

// file: hdl/zdfs_loop_flags.sv
`timescale 1ns/100ps
module zdfs_loop_flags (
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic sys_rst_in,
	// flag carrier
	zdfs_flag_if.flag_side fl
);
	import zdfs_pkg::*;

	zdfs_hl_t state_reg;
	zdfs_hl_t state_next;
	logic     entry_reg;
	logic     entry_next;
	logic     exit_reg;
	logic     exit_next;
	logic     enter_ev;
	logic     leave_ev;

	always_comb begin
		state_next = state_reg;
		enter_ev   = 1'b0;
		leave_ev   = 1'b0;
		unique case (state_reg)
			ZDFS_HL_OFF: begin
				if (fl.hitless_req) begin
					state_next = ZDFS_HL_ON;
					enter_ev   = 1'b1;
				end
			end
			ZDFS_HL_ON: begin
				if (!fl.hitless_req) begin
					state_next = ZDFS_HL_OFF;
					leave_ev   = 1'b1;
				end
			end
			default: state_next = ZDFS_HL_OFF;
		endcase
		// set wins over a clear in the same cycle
		entry_next = enter_ev | (entry_reg & ~fl.clr_entry);
		exit_next  = leave_ev | (exit_reg & ~fl.clr_exit);
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= ZDFS_HL_OFF;
			entry_reg <= 1'b0;
			exit_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			entry_reg <= entry_next;
			exit_reg  <= exit_next;
		end
	end

	assign fl.entry_flag = entry_reg;
	assign fl.exit_flag  = exit_reg;
	assign fl.hitless_on = (state_reg == ZDFS_HL_ON);
endmodule

// file: hdl/zdfs_pkg.sv
// Function
// - the 2-bit mode field selects buildout (0), internal zero delay (1), external zero delay (3); 2 is unused.
// - internal zero delay takes feedback from the output divider chosen by the 5-bit select field.
// - loop zero values 0..5 pick pairs a,b,c pos/neg; loop one values 0..3 pick pairs a,b; others n/a.
// - external zero delay uses the same field: 0..3 primary refs, 4..7 auxiliary refs, 8..31 n/a.
// - with an integer divider in internal zero delay the feedback phase offset is held at zero.
// - in zero delay the output phase moves gradually toward the new reference instead of jumping.
// - entering hitless operation latches bit 4 of that loop's status.
// - leaving hitless operation latches bit 3 of that loop's status.
// - the entry and exit bits stay set until cleared by bits 4 and 3 of the loop's clear vector.
// - external zero delay raises the same entry and exit flags as internal zero delay.
// - in internal zero delay, aux oscillator, timestamp ingress or other-loop sources use R of one.
package zdfs_pkg;
	localparam int          NUM_LOOPS      = 2;
	localparam int          MODE_W         = 2;
	localparam int          SEL_W          = 5;
	localparam int          INT_FB_W       = 6;
	localparam int          EXT_FB_W       = 8;
	localparam int          STAT_W         = 8;
	localparam int          SRC_W          = 2;
	localparam int          R_W            = 16;
	localparam int          PHASE_W        = 24;
	localparam int          STAT_ENTRY_BIT = 4;
	localparam int          STAT_EXIT_BIT  = 3;
	localparam logic [1:0]  MODE_BUILDOUT  = 2'h0;
	localparam logic [1:0]  MODE_INT_ZD    = 2'h1;
	localparam logic [1:0]  MODE_UNUSED    = 2'h2;
	localparam logic [1:0]  MODE_EXT_ZD    = 2'h3;
	localparam logic [4:0]  LOOP0_INT_CNT  = 5'h06;
	localparam logic [4:0]  LOOP1_INT_CNT  = 5'h04;
	localparam logic [4:0]  EXT_FB_CNT     = 5'h08;
	localparam logic [1:0]  SRC_REF        = 2'h0;
	localparam logic [1:0]  SRC_AUX_OSC    = 2'h1;
	localparam logic [1:0]  SRC_TS_INGRESS = 2'h2;
	localparam logic [1:0]  SRC_OTHER_LOOP = 2'h3;
	localparam logic [15:0] R_UNITY        = 16'h0001;
	localparam logic [23:0] PHASE_SLEW     = 24'h000010;
	localparam logic [23:0] PHASE_ZERO     = 24'h000000;
	localparam logic [7:0]  STAT_RESET     = 8'h00;
	typedef enum logic [1:0] {
		ZDFS_HL_OFF = 2'b01,
		ZDFS_HL_ON  = 2'b10
	} zdfs_hl_t;
endpackage

// file: hdl/zdfs_top.sv
`timescale 1ns/100ps
module zdfs_top (
	// clock and reset
	input  wire logic                                   mclk_in,
	input  wire logic                                   sys_rst_in,
	// per-loop translation profile fields
	input  wire logic [1:0][zdfs_pkg::MODE_W-1:0]       mode_in,
	input  wire logic [1:0][zdfs_pkg::SEL_W-1:0]        fb_sel_in,
	input  wire logic [1:0][zdfs_pkg::SRC_W-1:0]        src_kind_in,
	input  wire logic [1:0][zdfs_pkg::R_W-1:0]          r_div_in,
	input  wire logic [1:0]                             n_int_only_in,
	// per-loop acquisition and phase
	input  wire logic [1:0]                             acquire_in,
	input  wire logic [1:0][zdfs_pkg::PHASE_W-1:0]      phase_target_in,
	input  wire logic [1:0][zdfs_pkg::PHASE_W-1:0]      meas_offset_in,
	// per-loop status clear
	input  wire logic [1:0][zdfs_pkg::STAT_W-1:0]       irq_clr_in,
	// feedback selection
	output logic      [1:0][zdfs_pkg::INT_FB_W-1:0]     int_fb_sel_out,
	output logic      [1:0][zdfs_pkg::EXT_FB_W-1:0]     ext_fb_sel_out,
	output logic      [1:0]                             fb_sel_bad_out,
	output logic      [1:0]                             mode_bad_out,
	// loop arithmetic
	output logic      [1:0][zdfs_pkg::R_W-1:0]          r_eff_out,
	output logic      [1:0][zdfs_pkg::PHASE_W-1:0]      fb_offset_out,
	output logic      [1:0][zdfs_pkg::PHASE_W-1:0]      out_phase_out,
	output logic      [1:0]                             frac_warn_out,
	// status
	output logic      [1:0][zdfs_pkg::STAT_W-1:0]       status_out,
	output logic      [1:0]                             hitless_out
);
	import zdfs_pkg::*;

	// mode decode
	function automatic logic is_zd(input logic [MODE_W-1:0] m);
		is_zd = (m == MODE_INT_ZD) || (m == MODE_EXT_ZD);
	endfunction

	function automatic logic is_int_zd(input logic [MODE_W-1:0] m);
		is_int_zd = (m == MODE_INT_ZD);
	endfunction

	function automatic logic is_ext_zd(input logic [MODE_W-1:0] m);
		is_ext_zd = (m == MODE_EXT_ZD);
	endfunction

	// internal divider choice, limit depends on loop
	function automatic logic [INT_FB_W-1:0] int_dec(
		input logic [SEL_W-1:0] s,
		input logic [SEL_W-1:0] lim
	);
		int_dec = '0;
		if (s < lim) begin
			int_dec = INT_FB_W'(1) << s[2:0];
		end
	endfunction

	// external feedback input choice
	function automatic logic [EXT_FB_W-1:0] ext_dec(
		input logic [SEL_W-1:0] s
	);
		ext_dec = '0;
		if (s < EXT_FB_CNT) begin
			ext_dec = EXT_FB_W'(1) << s[2:0];
		end
	endfunction

	// sources that bypass the reference divider
	function automatic logic r_bypass(input logic [SRC_W-1:0] k);
		r_bypass = (k == SRC_AUX_OSC) || (k == SRC_TS_INGRESS)
			|| (k == SRC_OTHER_LOOP);
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
			localparam logic [SEL_W-1:0] INT_LIM =
				(g == 0) ? LOOP0_INT_CNT : LOOP1_INT_CNT;

			zdfs_flag_if fl ();

			logic [INT_FB_W-1:0] int_reg;
			logic [INT_FB_W-1:0] int_next;
			logic [EXT_FB_W-1:0] ext_reg;
			logic [EXT_FB_W-1:0] ext_next;
			logic                bad_reg;
			logic                bad_next;
			logic                mbad_reg;
			logic                mbad_next;
			logic [R_W-1:0]      r_reg;
			logic [R_W-1:0]      r_next;
			logic [PHASE_W-1:0]  off_reg;
			logic [PHASE_W-1:0]  off_next;
			logic [PHASE_W-1:0]  ph_reg;
			logic [PHASE_W-1:0]  ph_next;
			logic [PHASE_W-1:0]  ph_diff;
			logic                warn_reg;
			logic                warn_next;
			logic [STAT_W-1:0]   stat_vec;

			// feedback selection
			always_comb begin
				int_next  = '0;
				ext_next  = '0;
				bad_next  = 1'b0;
				mbad_next = (mode_in[g] == MODE_UNUSED);
				if (is_int_zd(mode_in[g])) begin
					int_next = int_dec(fb_sel_in[g], INT_LIM);
					bad_next = (fb_sel_in[g] >= INT_LIM);
				end else if (is_ext_zd(mode_in[g])) begin
					ext_next = ext_dec(fb_sel_in[g]);
					bad_next = (fb_sel_in[g] >= EXT_FB_CNT);
				end
			end

			always_ff @(posedge mclk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					int_reg  <= '0;
					ext_reg  <= '0;
					bad_reg  <= 1'b0;
					mbad_reg <= 1'b0;
				end else begin
					int_reg  <= int_next;
					ext_reg  <= ext_next;
					bad_reg  <= bad_next;
					mbad_reg <= mbad_next;
				end
			end

			// reference divide ratio and feedback offset
			always_comb begin
				r_next = r_div_in[g];
				if (is_int_zd(mode_in[g]) && r_bypass(src_kind_in[g])) begin
					r_next = R_UNITY;
				end
				off_next = meas_offset_in[g];
				if (is_int_zd(mode_in[g]) && n_int_only_in[g]) begin
					off_next = PHASE_ZERO;
				end
				warn_next = is_zd(mode_in[g]) && !n_int_only_in[g];
			end

			always_ff @(posedge mclk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					r_reg    <= R_UNITY;
					off_reg  <= PHASE_ZERO;
					warn_reg <= 1'b0;
				end else begin
					r_reg    <= r_next;
					off_reg  <= off_next;
					warn_reg <= warn_next;
				end
			end

			// output phase: slews in zero delay, builds out otherwise
			always_comb begin
				ph_diff = phase_target_in[g] - ph_reg;
				ph_next = phase_target_in[g];
				if (is_zd(mode_in[g])) begin
					if (ph_diff[PHASE_W-1]) begin
						if ((ph_reg - phase_target_in[g]) > PHASE_SLEW) begin
							ph_next = ph_reg - PHASE_SLEW;
						end
					end else if (ph_diff > PHASE_SLEW) begin
						ph_next = ph_reg + PHASE_SLEW;
					end
				end
			end

			always_ff @(posedge mclk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					ph_reg <= PHASE_ZERO;
				end else begin
					ph_reg <= ph_next;
				end
			end

			// hitless tracking and latched flags
			assign fl.hitless_req = is_zd(mode_in[g]) && acquire_in[g];
			assign fl.clr_entry = irq_clr_in[g][STAT_ENTRY_BIT];
			assign fl.clr_exit  = irq_clr_in[g][STAT_EXIT_BIT];

			zdfs_loop_flags u_flags (
				.mclk_in    (mclk_in),
				.sys_rst_in (sys_rst_in),
				.fl         (fl.flag_side)
			);

			always_comb begin
				stat_vec = STAT_RESET;
				stat_vec[STAT_ENTRY_BIT] = fl.entry_flag;
				stat_vec[STAT_EXIT_BIT]  = fl.exit_flag;
			end

			assign status_out[g]     = stat_vec;
			assign hitless_out[g]    = fl.hitless_on;
			assign int_fb_sel_out[g] = int_reg;
			assign ext_fb_sel_out[g] = ext_reg;
			assign fb_sel_bad_out[g] = bad_reg;
			assign mode_bad_out[g]   = mbad_reg;
			assign r_eff_out[g]      = r_reg;
			assign fb_offset_out[g]  = off_reg;
			assign out_phase_out[g]  = ph_reg;
			assign frac_warn_out[g]  = warn_reg;
		end
	endgenerate
endmodule

// file: verif/test_zero_delay_feedback_select.sv
`timescale 1ns/100ps
`define CHK(a, b) begin \
	comparisons++; \
	if ((a) !== (b)) begin \
		n_mismatch++; \
		$display("wrong value at %0t got %h exp %h", $time, (a), (b)); \
	end \
end
module test_zero_delay_feedback_select;
	import zdfs_pkg::*;
	logic                   mclk_in = 1'b0;
	logic                   sys_rst_in = 1'b1;
	logic [1:0][1:0]        mode_in, src_kind_in, clr_req;
	logic [1:0][4:0]        fb_sel_in;
	logic [1:0][15:0]       r_div_in, r_eff_out;
	logic [1:0]             n_int_only_in, acquire_in, hitless_out;
	logic [1:0]             fb_sel_bad_out, mode_bad_out, frac_warn_out;
	logic [1:0][23:0]       phase_target_in, meas_offset_in;
	logic [1:0][23:0]       fb_offset_out, out_phase_out;
	logic [1:0][7:0]        irq_clr_in, ext_fb_sel_out, status_out;
	logic [1:0][5:0]        int_fb_sel_out;
	logic [1:0]             m;
	logic [4:0]             s;
	integer                 seed = 48;
	int                     n_mismatch = 0;
	int                     comparisons = 0;
	always #4 mclk_in = ~mclk_in;
	zdfs_top i_dut (.mclk_in, .sys_rst_in, .mode_in, .fb_sel_in,
		.src_kind_in, .r_div_in, .n_int_only_in, .acquire_in,
		.phase_target_in, .meas_offset_in, .irq_clr_in, .int_fb_sel_out,
		.ext_fb_sel_out, .fb_sel_bad_out, .mode_bad_out, .r_eff_out,
		.fb_offset_out, .out_phase_out, .frac_warn_out, .status_out,
		.hitless_out);
	zdfs_sw_model i_sw (.mode_in, .clr_req_in(clr_req),
		.irq_clr_out(irq_clr_in), .n_int_only_out(n_int_only_in));
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rnd;
		for (int l = 0; l < 2; l++) begin
			src_kind_in[l] = 2'($random(seed));
			r_div_in[l] = 16'($random(seed));
			phase_target_in[l] = 24'($random(seed));
			meas_offset_in[l] = 24'($random(seed));
		end
	endtask
	// watchdog, several times the expected run
	initial begin
		#10000;
		n_mismatch++;
		summarize();
	end
	initial begin
		mode_in = '0;
		fb_sel_in = '0;
		acquire_in = '0;
		clr_req = '0;
		rnd();
		repeat (4) @(negedge mclk_in);
		`CHK(r_eff_out, {2{R_UNITY}})
		`CHK(status_out, 16'h0000)
		sys_rst_in = 1'b0;
		for (int i = 0; i < 128; i++) begin
			mode_in = {2{i[6:5]}};
			fb_sel_in = {2{i[4:0]}};
			rnd();
			@(negedge mclk_in);
			for (int l = 0; l < 2; l++) begin
				m = mode_in[l];
				s = fb_sel_in[l];
				`CHK(int_fb_sel_out[l], (m == MODE_INT_ZD
					&& s < (l ? 5'h04 : 5'h06)) ? 6'h01 << s : 6'h00)
				`CHK(ext_fb_sel_out[l], (m == MODE_EXT_ZD
					&& s < 5'h08) ? 8'h01 << s : 8'h00)
				`CHK(fb_sel_bad_out[l], (m == MODE_EXT_ZD && s > 5'h07)
					|| (m == MODE_INT_ZD && s >= (l ? 5'h04 : 5'h06)))
				`CHK(mode_bad_out[l], m == MODE_UNUSED)
				`CHK(r_eff_out[l], (m == MODE_INT_ZD && src_kind_in[l]
					!= SRC_REF) ? R_UNITY : r_div_in[l])
				`CHK(fb_offset_out[l], (m == MODE_INT_ZD)
					? PHASE_ZERO : meas_offset_in[l])
				`CHK(frac_warn_out[l], 1'b0)
				if (m == MODE_BUILDOUT)
					`CHK(out_phase_out[l], phase_target_in[l])
			end
		end
		$display("test selection sweep done");
		// integer ratios and a separate looped-back input assumed
		mode_in = {MODE_EXT_ZD, MODE_INT_ZD};
		acquire_in = 2'h3;
		@(negedge mclk_in);
		`CHK(hitless_out, 2'h3)
		`CHK(status_out, {2{8'h10}})
		clr_req = {2{2'h2}};
		@(negedge mclk_in);
		`CHK(status_out, 16'h0000)
		clr_req = '0;
		acquire_in = 2'h0;
		@(negedge mclk_in);
		`CHK(hitless_out, 2'h0)
		repeat (3) @(negedge mclk_in);
		`CHK(status_out, {2{8'h08}})
		clr_req = {2{2'h1}};
		@(negedge mclk_in);
		`CHK(status_out, 16'h0000)
		$display("test hitless flags done");
		for (int i = 0; i < 200; i++) begin
			mode_in = 4'($random(seed));
			acquire_in = 2'($random(seed));
			clr_req = 4'($random(seed));
			rnd();
			@(negedge mclk_in);
		end
		$display("test random traffic done");
		summarize();
	end
endmodule

// file: verif/zdfs_assertions.sv
`timescale 1ns/100ps
module zdfs_assertions (
	// clock and reset
	input wire logic             mclk_in,
	input wire logic             sys_rst_in,
	// watched inputs
	input wire logic [1:0][1:0]  mode_in,
	input wire logic [1:0][4:0]  fb_sel_in,
	input wire logic [1:0][1:0]  src_kind_in,
	input wire logic [1:0]       acquire_in,
	input wire logic [1:0][7:0]  irq_clr_in,
	// watched outputs
	input wire logic [1:0][5:0]  int_fb_sel_out,
	input wire logic [1:0][7:0]  ext_fb_sel_out,
	input wire logic [1:0]       mode_bad_out,
	input wire logic [1:0][15:0] r_eff_out,
	input wire logic [1:0][23:0] out_phase_out,
	input wire logic [1:0][7:0]  status_out,
	input wire logic [1:0]       hitless_out
);
	import zdfs_pkg::*;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_zd_acq;
		mode_in[0][0] && acquire_in[0];
	endsequence
	property p_int_sel;
		mode_in[0] == MODE_INT_ZD && fb_sel_in[0] < 5'h06
		|=> int_fb_sel_out[0] == 6'h01 << $past(fb_sel_in[0]);
	endproperty
	a_int_sel: assert property (p_int_sel) else $error("bad int sel");
	property p_ext_sel;
		mode_in[1] == MODE_EXT_ZD && fb_sel_in[1] < 5'h08
		|=> ext_fb_sel_out[1] == 8'h01 << $past(fb_sel_in[1]);
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("bad ext sel");
	property p_mode_bad;
		mode_in[0] == MODE_UNUSED |=> mode_bad_out[0]
		&& int_fb_sel_out[0] == 6'h00 && ext_fb_sel_out[0] == 8'h00;
	endproperty
	a_mode_bad: assert property (p_mode_bad) else $error("bad mode");
	property p_r_unity;
		mode_in[1] == MODE_INT_ZD && src_kind_in[1] != SRC_REF
		|=> r_eff_out[1] == R_UNITY;
	endproperty
	a_r_unity: assert property (p_r_unity) else $error("bad r");
	property p_entry;
		s_zd_acq ##0 !hitless_out[0] |=> hitless_out[0] && status_out[0][4];
	endproperty
	a_entry: assert property (p_entry) else $error("no entry flag");
	property p_exit;
		hitless_out[0] ##0 !(mode_in[0][0] && acquire_in[0])
		|=> !hitless_out[0] && status_out[0][3];
	endproperty
	a_exit: assert property (p_exit) else $error("no exit flag");
	property p_hold;
		status_out[1][3] && !irq_clr_in[1][3] |=> status_out[1][3];
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_slew;
		mode_in[0][0] |=> out_phase_out[0] - $past(out_phase_out[0])
		<= PHASE_SLEW || $past(out_phase_out[0]) - out_phase_out[0]
		<= PHASE_SLEW;
	endproperty
	a_slew: assert property (p_slew) else $error("phase jump");
endmodule
bind zdfs_top zdfs_assertions i_chk (
	.mclk_in, .sys_rst_in, .mode_in, .fb_sel_in, .src_kind_in,
	.acquire_in, .irq_clr_in, .int_fb_sel_out, .ext_fb_sel_out,
	.mode_bad_out, .r_eff_out, .out_phase_out, .status_out, .hitless_out
);

// file: verif/zdfs_sw_model.sv
`timescale 1ns/100ps
module zdfs_sw_model (
	// profile and clear requests
	input  wire logic [1:0][1:0] mode_in,
	input  wire logic [1:0][1:0] clr_req_in,
	// register writes
	output logic      [1:0][7:0] irq_clr_out,
	output logic      [1:0]      n_int_only_out
);
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			irq_clr_out[i] = {3'h0, clr_req_in[i], 3'h0};
			n_int_only_out[i] = mode_in[i][0];
		end
	end
endmodule
